// ===== rtl/fvi_ctrl.sv
// fvi_ctrl.sv: four-level vectored interrupt controller top
// assumes: core gives instruction-boundary and write strobes on ref_clk
// assumes: pins idle high; peripheral events are one-clock pulses
`timescale 1ns/100ps
`include "fvi_cfg.svh"

// Notes on behaviour
// - thirteen sources, each with flag, enable, priority, vector
// - external pins select edge or level trigger per pin
// - edge mode: high sample then low sample sets the flag
// - edge mode external flag cleared on vectoring
// - level mode flag follows the inverted pin, not cleared on vectoring
// - timer overflow sets flag, vectoring clears it
// - watchdog timeout sets flag; extended enable bit gates it
// - serial rx/tx flags share one source, software clears only
// - software may write every flag except level-mode pin flags, a set raises a request
// - per-source enables plus a global enable that blocks all
// - conversion done sets flag, software clears it
// - comparator toggles set flags, software clears them
// - two-wire status event sets flag, software clears it
// - brake event sets flag, software clears it
// - flags sampled and priority resolved every machine cycle
// - call only at last cycle, no blocking write, no return
// - requests are not latched between polling cycles
// - call pushes program counter only, then loads vector
// - vectors 0003h to 0033h for the first seven sources
// - vectors 003Bh to 0073h for the rest, gaps unused
// - return-from-interrupt ends service, plain return does not
// - two priority bits per source give levels 0 to 3
// - equal levels resolved by fixed arbitration rank
// - only a strictly higher level preempts a routine
module fvi_ctrl (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// external pins
	input wire logic ext_irq_pin_0_in,
	input wire logic ext_irq_pin_1_in,
	// configuration
	input wire logic ext0_edge_select_in,
	input wire logic ext1_edge_select_in,
	input wire logic global_irq_enable_in,
	input wire logic [`FVI_NUM_SRC-1:0] src_enable_in,
	input wire logic [5:0] priority_low_bits_a_in,
	input wire logic [5:0] priority_high_bits_a_in,
	input wire logic [5:0] priority_low_bits_b_in,
	input wire logic [5:0] priority_high_bits_b_in,
	input wire logic [7:0] watchdog_control_reg_in,
	input wire logic [7:0] extended_enable_reg_in,
	// peripheral event pulses
	input wire logic timer0_overflow_in,
	input wire logic timer1_overflow_in,
	input wire logic watchdog_timeout_in,
	input wire logic serial_rx_done_in,
	input wire logic serial_tx_done_in,
	input wire logic conversion_done_in,
	input wire logic comparator_a_toggle_in,
	input wire logic comparator_b_toggle_in,
	input wire logic twowire_status_in,
	input wire logic pwm_brake_in,
	input wire logic brownout_in,
	input wire logic keyboard_in,
	// software flag writes, index = source, serial uses the rx/tx pair
	input wire logic [`FVI_NUM_SRC-1:0] flag_wr_in,
	input wire logic [`FVI_NUM_SRC-1:0] flag_wdata_in,
	input wire logic ser_tx_wr_in,
	input wire logic ser_tx_wdata_in,
	// core handshake
	input wire logic last_cycle_in,
	input wire logic cfg_write_in,
	input wire logic return_from_interrupt_in,
	input wire logic call_done_in,
	input wire logic [15:0] pc_in,
	// outputs
	output logic call_req_out,
	output logic [15:0] vector_out,
	output logic [15:0] push_pc_out,
	output logic [`FVI_NUM_SRC-1:0] flags_out,
	output logic serial_tx_done_flag_out,
	output logic [`FVI_NUM_LVL-1:0] in_service_out,
	output logic mc_strobe_out
);

////////////////////////////////////////////////////////////////////////////

	// every register of the block, built whole in s_d each clock
	typedef struct packed {
		fvi_pkg::fvi_state_t st;
		logic [`FVI_MC_CNT_W-1:0] mc_cnt;
		logic mc_tick;
		logic [2:0] e0_sync;
		logic [2:0] e1_sync;
		logic e0_lvl;
		logic e1_lvl;
		logic e0_prev;
		logic e1_prev;
		fvi_pkg::fvi_src_vec_t flag;
		logic tx_flag;
		logic [`FVI_NUM_LVL-1:0] isr;
		logic call;
		logic [3:0] call_src;
		fvi_pkg::fvi_addr_t vec;
		fvi_pkg::fvi_addr_t push_pc;
	} fvi_state_s_t;

	fvi_state_s_t s_q;
	fvi_state_s_t s_d;
	fvi_arb_if arb_bus ();
	fvi_pkg::fvi_src_vec_t hw_set;
	fvi_pkg::fvi_src_vec_t req;
	logic [`FVI_NUM_SRC-1:0] en_eff;
	logic e0_now;
	logic e1_now;
	logic e0_fall;
	logic e1_fall;

	fvi_arbiter u_arb (
		.a(arb_bus.arb)
	);

////////////////////////////////////////////////////////////////////////////
// vector lookup

	function automatic fvi_pkg::fvi_addr_t vec_of(input logic [3:0] s);
		case (s)
			4'h0: vec_of = `FVI_VEC_EXT0;
			4'h1: vec_of = `FVI_VEC_BROWN;
			4'h2: vec_of = `FVI_VEC_WDOG;
			4'h3: vec_of = `FVI_VEC_TMR0;
			4'h4: vec_of = `FVI_VEC_TWI;
			4'h5: vec_of = `FVI_VEC_ADC;
			4'h6: vec_of = `FVI_VEC_EXT1;
			4'h7: vec_of = `FVI_VEC_KBD;
			4'h8: vec_of = `FVI_VEC_CMPA;
			4'h9: vec_of = `FVI_VEC_TMR1;
			4'hA: vec_of = `FVI_VEC_CMPB;
			4'hB: vec_of = `FVI_VEC_SER;
			4'hC: vec_of = `FVI_VEC_BRAKE;
			// codes above twelve never win arbitration
			default: vec_of = `FVI_VEC_BRAKE;
		endcase
	endfunction

////////////////////////////////////////////////////////////////////////////
// combinational helpers

	// a pin level counts only once the 2nd and 3rd stages agree
	assign e0_now = (s_q.e0_sync[1] == s_q.e0_sync[2]) ?
		s_q.e0_sync[2] : s_q.e0_lvl;
	assign e1_now = (s_q.e1_sync[1] == s_q.e1_sync[2]) ?
		s_q.e1_sync[2] : s_q.e1_lvl;
	// only machine-cycle samples are compared; a shorter pulse counts only if it is low at a tick
	assign e0_fall = s_q.mc_tick && s_q.e0_prev && !s_q.e0_lvl;
	assign e1_fall = s_q.mc_tick && s_q.e1_prev && !s_q.e1_lvl;

	// one-clock event pulses; they win over any clear in the same cycle
	always_comb begin
		hw_set = '0;
		hw_set[`FVI_SRC_EXT0] = e0_fall;
		hw_set[`FVI_SRC_EXT1] = e1_fall;
		hw_set[`FVI_SRC_TMR0] = timer0_overflow_in;
		hw_set[`FVI_SRC_TMR1] = timer1_overflow_in;
		hw_set[`FVI_SRC_WDOG] = watchdog_timeout_in;
		hw_set[`FVI_SRC_SER] = serial_rx_done_in;
		hw_set[`FVI_SRC_ADC] = conversion_done_in;
		hw_set[`FVI_SRC_CMPA] = comparator_a_toggle_in;
		hw_set[`FVI_SRC_CMPB] = comparator_b_toggle_in;
		hw_set[`FVI_SRC_TWI] = twowire_status_in;
		hw_set[`FVI_SRC_BRAKE] = pwm_brake_in;
		hw_set[`FVI_SRC_BROWN] = brownout_in;
		hw_set[`FVI_SRC_KBD] = keyboard_in;
	end

	always_comb begin
		en_eff = src_enable_in;
		en_eff[`FVI_SRC_WDOG] = src_enable_in[`FVI_SRC_WDOG] &&
			extended_enable_reg_in[`FVI_XEN_WDOG_BIT];
		req = s_q.flag;
		req[`FVI_SRC_SER] = s_q.flag[`FVI_SRC_SER] | s_q.tx_flag;
		// the watchdog flag itself lives in the watchdog control reg
		req[`FVI_SRC_WDOG] = s_q.flag[`FVI_SRC_WDOG] |
			watchdog_control_reg_in[`FVI_WDCTL_FLAG_BIT];
		// live flags only, nothing pending is remembered
		req = req & en_eff & {`FVI_NUM_SRC{global_irq_enable_in}};
	end

	assign arb_bus.req = req;
	// {high, low} per source, source 12 first; the converter has no pair
	// of its own in the six-bit sets and shares the brownout pair
	assign arb_bus.prio = {
		priority_high_bits_b_in[5], priority_low_bits_b_in[5],
		priority_high_bits_a_in[4], priority_low_bits_a_in[4],
		priority_high_bits_b_in[3], priority_low_bits_b_in[3],
		priority_high_bits_a_in[3], priority_low_bits_a_in[3],
		priority_high_bits_b_in[2], priority_low_bits_b_in[2],
		priority_high_bits_b_in[1], priority_low_bits_b_in[1],
		priority_high_bits_a_in[2], priority_low_bits_a_in[2],
		priority_high_bits_a_in[5], priority_low_bits_a_in[5],
		priority_high_bits_b_in[0], priority_low_bits_b_in[0],
		priority_high_bits_a_in[1], priority_low_bits_a_in[1],
		priority_high_bits_b_in[4], priority_low_bits_b_in[4],
		priority_high_bits_a_in[5], priority_low_bits_a_in[5],
		priority_high_bits_a_in[0], priority_low_bits_a_in[0]};
	assign arb_bus.busy = s_q.isr;

////////////////////////////////////////////////////////////////////////////
// next state

	always_comb begin
		logic clr_ack;
		s_d = s_q;
		clr_ack = 1'b0;
		// free-running divider: one poll tick every machine cycle
		s_d.mc_cnt = s_q.mc_cnt + `FVI_MC_CNT_W'(1);
		s_d.mc_tick = (s_q.mc_cnt == `FVI_MC_CNT_W'(`FVI_CLK_PER_MC - 1));
		s_d.e0_sync = {s_q.e0_sync[1:0], ext_irq_pin_0_in};
		s_d.e1_sync = {s_q.e1_sync[1:0], ext_irq_pin_1_in};
		s_d.e0_lvl = e0_now;
		s_d.e1_lvl = e1_now;
		if (s_q.mc_tick) begin
			s_d.e0_prev = s_q.e0_lvl;
			s_d.e1_prev = s_q.e1_lvl;
		end
		s_d.call = 1'b0;
		case (s_q.st)
			fvi_pkg::FVI_IDLE: begin
				// poll once per machine cycle on the core's strobe
				if (s_q.mc_tick && last_cycle_in && !cfg_write_in &&
					!return_from_interrupt_in && arb_bus.win) begin
					s_d.st = fvi_pkg::FVI_CALL;
					s_d.call = 1'b1;
					s_d.call_src = arb_bus.win_src;
					s_d.vec = vec_of(arb_bus.win_src);
					s_d.push_pc = pc_in;
					s_d.isr[arb_bus.win_lvl] = 1'b1;
				end
			end
			// no polling until the core has finished the call
			fvi_pkg::FVI_CALL: begin
				s_d.call = !call_done_in;
				if (call_done_in) begin
					s_d.st = fvi_pkg::FVI_IDLE;
					clr_ack = 1'b1;
				end
			end
			default: s_d.st = fvi_pkg::FVI_IDLE;
		endcase
		// return-from-interrupt releases the highest active level
		if (return_from_interrupt_in) begin
			if (s_q.isr[3]) s_d.isr[3] = 1'b0;
			else if (s_q.isr[2]) s_d.isr[2] = 1'b0;
			else if (s_q.isr[1]) s_d.isr[1] = 1'b0;
			else s_d.isr[0] = 1'b0;
		end
		// clear on vectoring first, software next, hardware sets win
		if (clr_ack) begin
			if (s_q.call_src == 4'(`FVI_SRC_TMR0) ||
				s_q.call_src == 4'(`FVI_SRC_TMR1) ||
				(s_q.call_src == 4'(`FVI_SRC_EXT0) && ext0_edge_select_in) ||
				(s_q.call_src == 4'(`FVI_SRC_EXT1) && ext1_edge_select_in))
				s_d.flag[s_q.call_src] = 1'b0;
		end
		for (int i = 0; i < `FVI_NUM_SRC; i++) begin
			if (flag_wr_in[i]) s_d.flag[i] = flag_wdata_in[i];
		end
		// tx done keeps its own flag but shares the serial vector
		if (ser_tx_wr_in) s_d.tx_flag = ser_tx_wdata_in;
		if (serial_tx_done_in) s_d.tx_flag = 1'b1;
		s_d.flag = s_d.flag | hw_set;
		// level mode: flag mirrors the inverse of the pin, so software
		// writes to a level-mode pin flag are lost
		if (!ext0_edge_select_in) s_d.flag[`FVI_SRC_EXT0] = !e0_now;
		if (!ext1_edge_select_in) s_d.flag[`FVI_SRC_EXT1] = !e1_now;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q <= '0;
			// pin history starts at the idle high level: no false edge
			s_q.e0_sync <= 3'h7;
			s_q.e1_sync <= 3'h7;
			s_q.e0_lvl <= 1'b1;
			s_q.e1_lvl <= 1'b1;
			s_q.e0_prev <= 1'b1;
			s_q.e1_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

////////////////////////////////////////////////////////////////////////////
// outputs, all registered

	assign call_req_out = s_q.call;
	assign vector_out = s_q.vec;
	assign push_pc_out = s_q.push_pc;
	assign flags_out = s_q.flag;
	assign serial_tx_done_flag_out = s_q.tx_flag;
	assign in_service_out = s_q.isr;
	assign mc_strobe_out = s_q.mc_tick;
endmodule

// ===== rtl/fvi_cfg.svh
// fvi_cfg.svh: constants of the four-level vectored interrupt unit
// assumes: included by bare name from rtl files, definitions only
`ifndef FVI_CFG_SVH
`define FVI_CFG_SVH

`define FVI_NUM_SRC 13
`define FVI_NUM_LVL 4
// source index = arbitration rank, 0 is ranked highest
`define FVI_SRC_EXT0 0
`define FVI_SRC_BROWN 1
`define FVI_SRC_WDOG 2
`define FVI_SRC_TMR0 3
`define FVI_SRC_TWI 4
`define FVI_SRC_ADC 5
`define FVI_SRC_EXT1 6
`define FVI_SRC_KBD 7
`define FVI_SRC_CMPA 8
`define FVI_SRC_TMR1 9
`define FVI_SRC_CMPB 10
`define FVI_SRC_SER 11
`define FVI_SRC_BRAKE 12
// vector addresses
`define FVI_VEC_EXT0 16'h0003
`define FVI_VEC_TMR0 16'h000B
`define FVI_VEC_EXT1 16'h0013
`define FVI_VEC_TMR1 16'h001B
`define FVI_VEC_SER 16'h0023
`define FVI_VEC_BROWN 16'h002B
`define FVI_VEC_TWI 16'h0033
`define FVI_VEC_KBD 16'h003B
`define FVI_VEC_CMPB 16'h0043
`define FVI_VEC_WDOG 16'h0053
`define FVI_VEC_ADC 16'h005B
`define FVI_VEC_CMPA 16'h0063
`define FVI_VEC_BRAKE 16'h0073
// watchdog control and extended enable register bit positions
`define FVI_WDCTL_FLAG_BIT 3
`define FVI_XEN_WDOG_BIT 4
// clocks per machine cycle
`define FVI_CLK_PER_MC 4
`define FVI_MC_CNT_W 2

`endif

// ===== rtl/fvi_pkg.sv
// fvi_pkg.sv: types of the four-level vectored interrupt unit
// assumes: fvi_cfg.svh is on the include path
`include "fvi_cfg.svh"
package fvi_pkg;
	typedef logic [`FVI_NUM_SRC-1:0] fvi_src_vec_t;
	typedef logic [1:0] fvi_lvl_t;
	typedef logic [15:0] fvi_addr_t;
	// gray along idle -> call -> idle
	typedef enum logic [1:0] {
		FVI_IDLE = 2'b00,
		FVI_CALL = 2'b01
	} fvi_state_t;
endpackage

// ===== rtl/fvi_arb_if.sv
// fvi_arb_if.sv: bundle between the controller and its priority resolver
// assumes: fvi_pkg compiled first
`timescale 1ns/100ps
`include "fvi_cfg.svh"
interface fvi_arb_if;
	fvi_pkg::fvi_src_vec_t req;
	logic [2*`FVI_NUM_SRC-1:0] prio;
	logic [`FVI_NUM_LVL-1:0] busy;
	logic win;
	logic [3:0] win_src;
	fvi_pkg::fvi_lvl_t win_lvl;
	modport ctl(output req, output prio, output busy,
		input win, input win_src, input win_lvl);
	modport arb(input req, input prio, input busy,
		output win, output win_src, output win_lvl);
endinterface

// ===== rtl/fvi_arbiter.sv
// fvi_arbiter.sv: combinational level then rank resolution
// assumes: requests already gated by enables; index order is the rank
`timescale 1ns/100ps
`include "fvi_cfg.svh"
module fvi_arbiter (
	fvi_arb_if.arb a
);
	logic [`FVI_NUM_LVL-1:0] lvl_hit;
	logic [`FVI_NUM_LVL-1:0][`FVI_NUM_SRC-1:0] at_lvl;

	genvar g;
	for (g = 0; g < `FVI_NUM_SRC; g++) begin : g_src
		for (genvar l = 0; l < `FVI_NUM_LVL; l++) begin : g_lvl
			assign at_lvl[l][g] = a.req[g] &&
				(a.prio[2*g +: 2] == 2'(l));
		end
	end

	always_comb begin
		logic found;
		logic [`FVI_NUM_LVL:0] above;
		found = 1'b0;
		above = '0;
		a.win = 1'b0;
		a.win_src = 4'h0;
		a.win_lvl = 2'h0;
		for (int i = 0; i < `FVI_NUM_LVL; i++) begin
			lvl_hit[i] = |at_lvl[i];
		end
		// a level is eligible only when it and all above are idle
		for (int l = `FVI_NUM_LVL - 1; l >= 0; l--) begin
			above[l] = above[l+1] | a.busy[l];
			if (!found && lvl_hit[l] && !above[l]) begin
				found = 1'b1;
				a.win = 1'b1;
				a.win_lvl = 2'(l);
				for (int s = `FVI_NUM_SRC - 1; s >= 0; s--) begin
					if (at_lvl[l][s]) begin
						a.win_src = 4'(s);
					end
				end
			end
		end
	end
endmodule

// ===== sim/fvi_ctrl_asserts.sv
// fvi_ctrl_asserts.sv: port checks of the interrupt controller
// assumes: bound to fvi_ctrl from the testbench file
`timescale 1ns/100ps
`include "fvi_cfg.svh"
module fvi_ctrl_asserts (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// watched inputs
	input wire logic global_irq_enable_in,
	input wire logic last_cycle_in,
	input wire logic cfg_write_in,
	input wire logic return_from_interrupt_in,
	input wire logic call_done_in,
	input wire logic [15:0] pc_in,
	// watched outputs
	input wire logic call_req_out,
	input wire logic [15:0] vector_out,
	input wire logic [15:0] push_pc_out,
	input wire logic [`FVI_NUM_LVL-1:0] in_service_out,
	input wire logic mc_strobe_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);
	////////////////////////////////////////////////////////////////////
	sequence s_gap;
		!mc_strobe_out [*3] ##1 mc_strobe_out;
	endsequence
	sequence s_hold;
		call_req_out && !call_done_in;
	endsequence
	property p_mc;
		mc_strobe_out |=> s_gap;
	endproperty
	property p_call;
		$rose(call_req_out) |-> $past(mc_strobe_out && last_cycle_in &&
			!cfg_write_in && !return_from_interrupt_in && global_irq_enable_in);
	endproperty
	property p_pc;
		$rose(call_req_out) |-> push_pc_out == $past(pc_in);
	endproperty
	// the three unused slots sit at 4Bh, 6Bh and 7Bh
	property p_vec;
		$rose(call_req_out) |-> vector_out[15:7] == 9'h000 &&
			vector_out[2:0] == 3'h3 &&
			!(vector_out[6:3] inside {4'h9, 4'hD, 4'hF});
	endproperty
	property p_hold;
		s_hold |=> call_req_out && $stable(vector_out) &&
			$stable(push_pc_out);
	endproperty
	property p_end;
		call_req_out && call_done_in |=> !call_req_out;
	endproperty
	// new marker must sit above every marker already set
	property p_lvl;
		$rose(call_req_out) |->
			(in_service_out & ~$past(in_service_out)) > $past(in_service_out);
	endproperty
	property p_return_from_interrupt;
		return_from_interrupt_in && in_service_out != 4'h0 |=>
			$onehot(in_service_out ^ $past(in_service_out)) &&
			(in_service_out ^ $past(in_service_out)) > in_service_out;
	endproperty
	////////////////////////////////////////////////////////////////////
	a_mc: assert property (p_mc) else $error("poll strobe period");
	a_call: assert property (p_call) else $error("call cause");
	a_pc: assert property (p_pc) else $error("pushed pc");
	a_vec: assert property (p_vec) else $error("vector slot");
	a_hold: assert property (p_hold) else $error("call hold");
	a_end: assert property (p_end) else $error("call end");
	a_lvl: assert property (p_lvl) else $error("preempt level");
	a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return_from_interrupt marker");
endmodule

// ===== sim/fvi_core_model.sv
// fvi_core_model.sv: core side, instruction ends and call completion
// assumes: same clock and reset as the controller
`timescale 1ns/100ps
module fvi_core_model #(
	parameter int SEED = 1
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// from controller
	input wire logic call_req_in,
	input wire logic mc_strobe_in,
	// to controller
	output logic last_cycle_out,
	output logic call_done_out,
	output logic [15:0] pc_out
);
	logic [3:0] wait_q;
	logic done_q;
	int seed = SEED;
	// random instruction lengths and call latencies, prompt to slow
	always @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			last_cycle_out <= 1'b0;
			call_done_out <= 1'b0;
			pc_out <= 16'h0000;
			wait_q <= 4'h0;
			done_q <= 1'b0;
		end else begin
			pc_out <= 16'($random(seed));
			if (mc_strobe_in) last_cycle_out <= 1'($random(seed));
			call_done_out <= 1'b0;
			if (!call_req_in) begin
				done_q <= 1'b0;
				wait_q <= 4'($random(seed));
			end else if (!done_q) begin
				if (wait_q == 4'h0) begin
					call_done_out <= 1'b1;
					done_q <= 1'b1;
				end else begin
					wait_q <= wait_q - 4'h1;
				end
			end
		end
	end
endmodule

// ===== sim/testbench.sv
// testbench.sv: random and directed checks of the interrupt controller
// assumes: rtl, checker and core model compiled before this file
`timescale 1ns/100ps
`include "fvi_cfg.svh"
`define CHK(g, e) chk(16'(g), 16'(e))
module testbench;
	logic ref_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic pin0 = 1'b1;
	logic edge0 = 1'b1;
	logic gen = 1'b0;
	logic cfgw = 1'b0;
	logic return_from_interrupt = 1'b0;
	logic stx_ev = 1'b0;
	logic stx_wr = 1'b0;
	logic [12:0] en = '0, ev = '0, fwr = '0, fwd = '0, m, flags;
	logic [5:0] pal = '0, pah = '0, pbl = '0, pbh = '0;
	logic [7:0] xen = 8'h10, wdc = 8'h00;
	logic call, done, last, stx_f, mcs;
	logic [15:0] vec, ppc, pc;
	logic [3:0] insvc;
	int seed, bad_count = 0, samples_checked = 0, w;
	bit s, top;
	localparam logic [15:0] VEC[13] = '{`FVI_VEC_EXT0, `FVI_VEC_BROWN,
		`FVI_VEC_WDOG, `FVI_VEC_TMR0, `FVI_VEC_TWI, `FVI_VEC_ADC,
		`FVI_VEC_EXT1, `FVI_VEC_KBD, `FVI_VEC_CMPA, `FVI_VEC_TMR1,
		`FVI_VEC_CMPB, `FVI_VEC_SER, `FVI_VEC_BRAKE};
	// priority bit per source, 16 added for the second set
	localparam int PMAP[13] = '{0, 5, 20, 1, 16, 5, 2, 17, 18, 3, 19, 4, 21};
	fvi_ctrl dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
		.ext_irq_pin_0_in(pin0), .ext_irq_pin_1_in(1'b1),
		.ext0_edge_select_in(edge0), .ext1_edge_select_in(1'b1),
		.global_irq_enable_in(gen), .src_enable_in(en),
		.priority_low_bits_a_in(pal), .priority_high_bits_a_in(pah),
		.priority_low_bits_b_in(pbl), .priority_high_bits_b_in(pbh),
		.watchdog_control_reg_in(wdc), .extended_enable_reg_in(xen),
		.timer0_overflow_in(ev[3]), .timer1_overflow_in(ev[9]),
		.watchdog_timeout_in(ev[2]), .serial_rx_done_in(ev[11]),
		.serial_tx_done_in(stx_ev), .conversion_done_in(ev[5]),
		.comparator_a_toggle_in(ev[8]), .comparator_b_toggle_in(ev[10]),
		.twowire_status_in(ev[4]), .pwm_brake_in(ev[12]),
		.brownout_in(ev[1]), .keyboard_in(ev[7]), .flag_wr_in(fwr),
		.flag_wdata_in(fwd), .ser_tx_wr_in(stx_wr), .ser_tx_wdata_in(1'b0),
		.last_cycle_in(last), .cfg_write_in(cfgw), .return_from_interrupt_in(return_from_interrupt),
		.call_done_in(done), .pc_in(pc), .call_req_out(call),
		.vector_out(vec), .push_pc_out(ppc), .flags_out(flags),
		.serial_tx_done_flag_out(stx_f), .in_service_out(insvc),
		.mc_strobe_out(mcs));
	fvi_core_model #(.SEED(91)) core (.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in), .call_req_in(call), .mc_strobe_in(mcs),
		.last_cycle_out(last), .call_done_out(done), .pc_out(pc));
	always #25 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) cfgw <= ($random(seed) & 3) == 0;
	////////////////////////////////////////////////////////////////////
	function automatic int lvl(int i);
		logic [5:0] l, h;
		l = PMAP[i] > 15 ? pbl : pal;
		h = PMAP[i] > 15 ? pbh : pah;
		return {h[PMAP[i] % 16], l[PMAP[i] % 16]};
	endfunction
	function automatic int winner(logic [12:0] r);
		int b = -1;
		for (int i = 0; i < 13; i++)
			if (r[i] && (b < 0 || lvl(i) > lvl(b))) b = i;
		return b;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	task automatic hang(bit c);
		if (c) begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic wflags(logic [12:0] k, logic [12:0] d);
		fwr <= k;
		fwd <= d;
		cyc(1);
		fwr <= '0;
		cyc(2);
	endtask
	task automatic wait_call(output bit seen);
		seen = 0;
		for (int i = 0; i < 300 && !seen; i++) begin
			cyc(1);
			seen = call === 1'b1;
		end
	endtask
	task automatic must_call();
		wait_call(s);
		hang(!s);
	endtask
	task automatic end_call();
		for (int i = 0; i < 300 && call !== 1'b0; i++)
			cyc(1);
		hang(call !== 1'b0);
		cyc(1);
	endtask
	task automatic ret();
		return_from_interrupt <= 1'b1;
		cyc(1);
		return_from_interrupt <= 1'b0;
		cyc(2);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		seed = 57037;
		cyc(16);
		rstn_in <= 1'b1;
		cyc(1);
		`CHK(insvc, 0);
		`CHK({call, flags}, 0);
		en <= 13'h1FFF;
		for (int i = 1; i < 13; i++) begin
			if (i == 6) continue;
			ev <= 13'(1) << i;
			cyc(1);
			ev <= '0;
			cyc(2);
			`CHK(flags[i], 1);
			wflags(13'(1) << i, '0);
			`CHK(flags[i], 0);
		end
		stx_ev <= 1'b1;
		cyc(1);
		stx_ev <= 1'b0;
		cyc(2);
		`CHK(stx_f, 1);
		stx_wr <= 1'b1;
		cyc(1);
		stx_wr <= 1'b0;
		cyc(2);
		`CHK(stx_f, 0);
		pin0 <= 1'b0;
		cyc(10);
		`CHK(flags[0], 1);
		pin0 <= 1'b1;
		cyc(10);
		`CHK(flags[0], 1);
		wflags(13'h0001, '0);
		edge0 <= 1'b0;
		pin0 <= 1'b0;
		gen <= 1'b1;
		must_call();
		`CHK(vec, `FVI_VEC_EXT0);
		end_call();
		`CHK(flags[0], 1);
		pin0 <= 1'b1;
		cyc(8);
		`CHK(flags[0], 0);
		ret();
		edge0 <= 1'b1;
		for (int i = 0; i < 13; i++) begin
			en <= 13'(1) << i;
			wflags(13'(1) << i, 13'(1) << i);
			must_call();
			`CHK(vec, VEC[i]);
			`CHK(insvc, 1);
			end_call();
			`CHK(flags[i], !(i inside {0, 3, 6, 9}));
			wflags(13'(1) << i, '0);
			ret();
			`CHK(insvc, 0);
		end
		en <= 13'h1FF7;
		wflags(13'h0008, 13'h0008);
		wait_call(s);
		`CHK(s, 0);
		gen <= 1'b0;
		en <= 13'h1FFF;
		wait_call(s);
		`CHK(s, 0);
		wflags(13'h0008, '0);
		gen <= 1'b1;
		en <= 13'h0004;
		xen <= 8'h00;
		wdc <= 8'(1) << `FVI_WDCTL_FLAG_BIT;
		wait_call(s);
		`CHK(s, 0);
		xen <= 8'(1) << `FVI_XEN_WDOG_BIT;
		must_call();
		`CHK(vec, `FVI_VEC_WDOG);
		end_call();
		wdc <= 8'h00;
		ret();
		`CHK(insvc, 0);
		en <= 13'h1FFF;
		for (int t = 0; t < 30; t++) begin
			{pal, pah, pbl, pbh} <= 24'($random(seed));
			m = 13'($random(seed)) | (13'(1) << (t % 13));
			wflags(13'h1FFF, m);
			must_call();
			w = winner(m);
			`CHK(vec, VEC[w]);
			`CHK(insvc, 4'(1) << lvl(w));
			end_call();
			top = lvl(w) == 3;
			// flags back first, so no poll sees new levels with stale flags
			wflags(13'h1FFF, m);
			{pal, pah, pbl, pbh} <= '1;
			if (top) begin
				wait_call(s);
				`CHK(s, 0);
			end else begin
				must_call();
				`CHK(vec, VEC[winner(m)]);
				end_call();
			end
			wflags(13'h1FFF, '0);
			if (!top) ret();
			ret();
			`CHK(insvc, 0);
		end
		complete_run();
	end
endmodule
bind fvi_ctrl fvi_ctrl_asserts chk_i (.ref_clk_in, .rstn_in,
	.global_irq_enable_in, .last_cycle_in, .cfg_write_in, .return_from_interrupt_in,
	.call_done_in, .pc_in, .call_req_out, .vector_out, .push_pc_out,
	.in_service_out, .mc_strobe_out);
